/* File: core/pfsp_regs.vh */
// constants for the program flash self-programming controller
`ifndef PFSP_REGS_VH
`define PFSP_REGS_VH
`define PFSP_BIT_RD 0
`define PFSP_BIT_WR 1
`define PFSP_BIT_WRITE_PERMIT 2
`define PFSP_BIT_ABORTED_WRITE_FLAG 3
`define PFSP_BIT_FREE 4
`define PFSP_BIT_PGD 7
`define PFSP_KEY1 8'h55
`define PFSP_KEY2 8'haa
`define PFSP_BUF_RESET 14'h3fff
`define PFSP_ROW_LSB 5
`define PFSP_LAST_WORD 2'h3
`define PFSP_ERASE_US 2000
`define PFSP_WRITE_US 2000
`define PFSP_MHZ 250
`define PFSP_CNT_W 20
`endif

/* File: core/pfsp_ctrl.v */
// program flash self-programming sequencer with write buffer
`timescale 1ns/1ps
`include "pfsp_regs.vh"
// Functional notes
// - flash read uses first cycle after trigger; the second instruction is ignored
// - read data lands in data regs next cycle, held until reread or overwrite
// - self erase always clears a whole 32-word row
// - row chosen by upper 8 address bits; bits 4:0 ignored
// - erase/write starts only after 55h, AAh unlock then write trigger
// - two setup cycles after erase trigger, those instructions ignored
// - core execution halts about 2 ms during erase, clocks keep running
// - after erase execution resumes at third instruction after trigger
// - writes into protected segments are blocked
// - writes cover aligned four-word blocks, never crossing a boundary
// - block write only programs; software erases the row first
// - four 14-bit buffer entries selected by low two address bits
// - address not ending 11: buffer word only, trigger clears after a cycle
// - address ending 11: buffer, program block, one exec, one skip, halt
// - after long write execution resumes at third instruction after trigger
// - all buffer entries become 3FFF after every long write
// - triggers only set by software, cleared by hardware on completion
// - write trigger refused without permit; later permit clear harmless
// - write-done flag set when a write finishes, cleared by software
// - aborted-write flag set if reset hits a write; addr/data kept
module pfsp_ctrl #(
  parameter ADDR_W = 13,
  parameter ERASE_CYC = `PFSP_ERASE_US * `PFSP_MHZ,
  parameter WRITE_CYC = `PFSP_WRITE_US * `PFSP_MHZ
) (
  input wire mclk,
  input wire rst_n,
  input wire clkEn,
  // core register access, one write strobe per register
  input wire [7:0] wrData,
  input wire addrLowWe,
  input wire addrHighWe,
  input wire dataLowWe,
  input wire dataHighWe,
  input wire ctrlWe,
  input wire unlockWe,
  // any other core register access; breaks the unlock chain
  input wire regAccess,
  // configuration bits choosing the protected segments
  input wire [1:0] writeProtectConfig,
  // external or watchdog reset landing on a running write
  input wire abortReset,
  // software clear of the completion flag
  input wire writeDoneClr,
  // flash array side
  input wire [13:0] flashRdData,
  output reg [ADDR_W-1:0] flashAddr,
  output reg flashRdEn,
  output reg flashEraseEn,
  output reg flashProgEn,
  output reg [55:0] flashProgData,
  // to core
  output reg [7:0] addrLowReg,
  output reg [7:0] addrHighReg,
  output reg [7:0] dataLowReg,
  output reg [5:0] dataHighReg,
  output reg [7:0] accessControlReg,
  // core ignores the instruction in a cycle with skip high
  output reg skipInstr,
  output reg cpuHalt,
  output reg writeDoneFlag
);
  // cycle view, trigger accepted at edge 0:
  // read: array strobe after edge 0, data and skip after edge 1
  // short write: trigger bit after 0, cleared with the flag after 1
  // long write: skip, halt and program strobe after edge 1
  // erase: halt after edge 0, erase strobe after edge 2
  // both stalls then count the array time before done
  // all figures hold only while the clock enable stays high

  // sequencer states:
  // idle waits for a read request or an armed trigger
  // rd holds the array read slot; the core skips the instruction after it
  // eset spends the two erase setup cycles, core already stalled
  // lset lets one instruction run, skips the next, launches programming
  // busy counts down the array time with the core held
  // done clears the trigger and raises the completion flag
  localparam ST_IDLE = 3'h0;
  localparam ST_RD = 3'h1;
  localparam ST_ESET = 3'h2;
  localparam ST_LSET = 3'h3;
  localparam ST_BUSY = 3'h4;
  localparam ST_DONE = 3'h5;
  localparam UL_NONE = 2'h0;
  localparam UL_ONE = 2'h1;
  localparam UL_TWO = 2'h2;
  // counter loads, cut to the counter width by a part-select; the
  // default array times need 19 bits, wider settings need a wider counter
  localparam [31:0] ERASE_LOAD = ERASE_CYC - 1;
  localparam [31:0] WRITE_LOAD = WRITE_CYC - 1;

  reg [2:0] state_r;
  reg [2:0] state_nxt;
  reg [1:0] unlock_r;
  reg [`PFSP_CNT_W-1:0] cnt_r;
  reg [13:0] buf_r [0:3];
  reg eraseOp_r;
  reg setupCnt_r;
  wire [ADDR_W-1:0] fullAddr;
  wire [1:0] wordSel;
  wire wrTrigReq;
  wire armed;
  wire protHit;
  wire goWrite;
  wire anyAccess;
  wire rdReq;

  // the high byte's upper bits are stored but not used in the address
  assign fullAddr = {addrHighReg[ADDR_W-9:0], addrLowReg};
  // entry select comes from the low address bits only
  assign wordSel = addrLowReg[1:0];

  // trigger write attempt: software can only raise the bit
  assign wrTrigReq = ctrlWe & wrData[`PFSP_BIT_WR];
  // unlock must be immediately followed by the trigger access
  // keys must be the two accesses just before the trigger
  assign armed = (unlock_r == UL_TWO);

  // protected upper segments: config value sets how much is locked
  // 0 locks everything, 1 the top half, 2 the top three quarters,
  // 3 nothing; the bottom area stays writable longest
  assign protHit = (writeProtectConfig == 2'h0) ||
    (writeProtectConfig == 2'h1 && fullAddr[ADDR_W-1]) ||
    (writeProtectConfig == 2'h2 &&
     fullAddr[ADDR_W-1:ADDR_W-2] != 2'h0);
  // trigger accepted only if permitted, program space, idle and unlocked
  assign goWrite = wrTrigReq & armed &
    accessControlReg[`PFSP_BIT_WRITE_PERMIT] &
    accessControlReg[`PFSP_BIT_PGD] & ~accessControlReg[`PFSP_BIT_WR] &
    ~protHit & (state_r == ST_IDLE);

  // any other register strobe between keys and trigger breaks the
  // chain, so a stray store cannot arm a later trigger
  assign anyAccess = regAccess | addrLowWe | addrHighWe | dataLowWe |
    dataHighWe | ctrlWe;
  // program space reads only; a read request while busy is dropped,
  // otherwise its trigger bit would never be cleared
  assign rdReq = ctrlWe & wrData[`PFSP_BIT_RD] & wrData[`PFSP_BIT_PGD] &
    (state_r == ST_IDLE);

  // unlock tracker; any other register access breaks the chain
  // a repeated first key restarts the chain instead of breaking it
  // keys arrive on the unlock port, the trigger as a control write
  always @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      unlock_r <= UL_NONE;
    else if (clkEn)
    begin
      if (unlockWe && wrData == `PFSP_KEY1)
        unlock_r <= UL_ONE;
      else if (unlockWe && wrData == `PFSP_KEY2 && unlock_r == UL_ONE)
        unlock_r <= UL_TWO;
      else if (anyAccess || unlockWe)
        unlock_r <= UL_NONE;
    end
  end

  // sequencer next state
  always @*
  begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE:
      begin
        // erase wins over block write when row erase is selected
        if (goWrite && accessControlReg[`PFSP_BIT_FREE])
          state_nxt = ST_ESET;
        else if (goWrite && wordSel == `PFSP_LAST_WORD)
          state_nxt = ST_LSET;
        else if (goWrite)
          state_nxt = ST_DONE;
        else if (rdReq)
          state_nxt = ST_RD;
      end
      ST_RD: state_nxt = ST_IDLE;
      ST_ESET: state_nxt = setupCnt_r ? ST_BUSY : ST_ESET;
      ST_LSET: state_nxt = ST_BUSY;
      // busy leaves once the countdown reaches zero
      ST_BUSY: state_nxt = (cnt_r == 0) ? ST_DONE : ST_BUSY;
      ST_DONE: state_nxt = ST_IDLE;
      default: state_nxt = ST_IDLE;
    endcase
  end

  // main sequencer, registers and buffer
  always @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      // buffer entries are left alone; software refills all four
      state_r <= ST_IDLE;
      cnt_r <= {`PFSP_CNT_W{1'b0}};
      eraseOp_r <= 1'b0;
      setupCnt_r <= 1'b0;
      addrLowReg <= 8'h00;
      addrHighReg <= 8'h00;
      dataLowReg <= 8'h00;
      dataHighReg <= 6'h00;
      accessControlReg <= 8'h00;
      skipInstr <= 1'b0;
      cpuHalt <= 1'b0;
      writeDoneFlag <= 1'b0;
      flashAddr <= {ADDR_W{1'b0}};
      flashRdEn <= 1'b0;
      flashEraseEn <= 1'b0;
      flashProgEn <= 1'b0;
      flashProgData <= 56'h00;
    end
    else if (clkEn)
    begin
      // strobes to the array and the core last one cycle
      state_r <= state_nxt;
      flashRdEn <= 1'b0;
      flashEraseEn <= 1'b0;
      flashProgEn <= 1'b0;
      skipInstr <= 1'b0;
      // core stores to the address and data registers
      if (addrLowWe)
        addrLowReg <= wrData;
      if (addrHighWe)
        addrHighReg <= wrData;
      if (dataLowWe)
        dataLowReg <= wrData;
      if (dataHighWe)
        dataHighReg <= wrData[5:0];
      // software writes keep set-only trigger bits, busy locks space select
      if (ctrlWe)
      begin
        accessControlReg[`PFSP_BIT_FREE] <= wrData[`PFSP_BIT_FREE];
        accessControlReg[`PFSP_BIT_WRITE_PERMIT] <= wrData[`PFSP_BIT_WRITE_PERMIT];
        // aborted flag stays writable so software can clear it later
        accessControlReg[`PFSP_BIT_ABORTED_WRITE_FLAG] <= wrData[`PFSP_BIT_ABORTED_WRITE_FLAG];
        if (!accessControlReg[`PFSP_BIT_WR])
          accessControlReg[`PFSP_BIT_PGD] <= wrData[`PFSP_BIT_PGD];
        if (rdReq)
          accessControlReg[`PFSP_BIT_RD] <= 1'b1;
      end
      // accepted trigger: latch operation kind; permit may drop later
      if (goWrite)
      begin
        accessControlReg[`PFSP_BIT_WR] <= 1'b1;
        eraseOp_r <= accessControlReg[`PFSP_BIT_FREE];
      end
      // reset that hits a running write leaves address and data intact
      if (abortReset && accessControlReg[`PFSP_BIT_WR])
        accessControlReg[`PFSP_BIT_ABORTED_WRITE_FLAG] <= 1'b1;
      // software clear loses to a coinciding completion
      if (writeDoneClr)
        writeDoneFlag <= 1'b0;
      case (state_r)
        ST_IDLE:
        begin
          if (state_nxt == ST_RD)
          begin
            flashAddr <= fullAddr;
            flashRdEn <= 1'b1;
          end
          // erase stalls the core at once: both setup slots are ignored
          if (state_nxt == ST_ESET)
            cpuHalt <= 1'b1;
          setupCnt_r <= 1'b0;
        end
        ST_RD:
        begin
          // array answers this cycle; core skips the slot after this one
          {dataHighReg, dataLowReg} <= flashRdData;
          skipInstr <= 1'b1;
          accessControlReg[`PFSP_BIT_RD] <= 1'b0;
        end
        ST_ESET:
        begin
          // first setup cycle arms, the second starts the row erase
          setupCnt_r <= 1'b1;
          if (setupCnt_r)
          begin
            flashAddr <= {fullAddr[ADDR_W-1:`PFSP_ROW_LSB],
              {`PFSP_ROW_LSB{1'b0}}};
            flashEraseEn <= 1'b1;
            cnt_r <= ERASE_LOAD[`PFSP_CNT_W-1:0];
          end
        end
        ST_LSET:
        begin
          // next instruction ran; the following one is ignored
          skipInstr <= 1'b1;
          cpuHalt <= 1'b1;
          flashAddr <= {fullAddr[ADDR_W-1:2], 2'h0};
          flashProgData <= {buf_r[3], buf_r[2], buf_r[1], buf_r[0]};
          flashProgEn <= 1'b1;
          cnt_r <= WRITE_LOAD[`PFSP_CNT_W-1:0];
        end
        ST_BUSY:
        begin
          // halt drops as done is entered, one cycle before the flag; core resumes at third slot
          if (cnt_r != 0)
            cnt_r <= cnt_r - 1'b1;
          else
            cpuHalt <= 1'b0;
        end
        ST_DONE:
        begin
          accessControlReg[`PFSP_BIT_WR] <= 1'b0;
          // clearing permit mid-write has no effect: nothing here reads it
          writeDoneFlag <= 1'b1;
        end
        default: ;
      endcase
    end
  end

  // one write-buffer entry per word slot; entries are not reset, so
  // software must fill all four before the last word starts a program
  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1)
    begin : gBuf
      always @(posedge mclk)
      begin
        if (clkEn)
        begin
          // a finished long write returns the entry to the erased value
          if (state_r == ST_DONE && !eraseOp_r &&
            wordSel == `PFSP_LAST_WORD)
            buf_r[g] <= `PFSP_BUF_RESET;
          else if (goWrite && !accessControlReg[`PFSP_BIT_FREE] &&
            wordSel == g)
            buf_r[g] <= {dataHighReg, dataLowReg};
        end
      end
    end
  endgenerate
endmodule

/* File: tb/pfsp_ctrl_props.sv */
// timing assertions for the flash self-programming sequencer
`timescale 1ns/1ps
module pfsp_ctrl_props #(
  parameter ADDR_W = 13,
  parameter ERASE_CYC = 8,
  parameter WRITE_CYC = 8
) (
  input wire mclk,
  input wire rst_n,
  input wire writeDoneClr,
  input wire [1:0] writeProtectConfig,
  input wire [ADDR_W-1:0] flashAddr,
  input wire flashRdEn,
  input wire flashEraseEn,
  input wire flashProgEn,
  input wire [7:0] addrLowReg,
  input wire [7:0] accessControlReg,
  input wire skipInstr,
  input wire cpuHalt,
  input wire writeDoneFlag
);
  localparam LO = (ERASE_CYC < WRITE_CYC ? ERASE_CYC : WRITE_CYC) - 1;
  localparam HI = (ERASE_CYC > WRITE_CYC ? ERASE_CYC : WRITE_CYC) + 4;
  reg [19:0] haltCnt_r;
  // halted cycles; slack allows for the setup cycles around the stall
  always @(posedge mclk or negedge rst_n)
    if (!rst_n)
      haltCnt_r <= 20'h0;
    else
      haltCnt_r <= cpuHalt ? haltCnt_r + 20'h1 : 20'h0;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  rd_skip_a: assert property (flashRdEn |-> ##[1:2] skipInstr)
    else $error("no skip after read");
  short_wr_a: assert property ($rose(accessControlReg[1]) &&
    addrLowReg[1:0] != 2'h3 && !accessControlReg[4]
    |=> !accessControlReg[1] && writeDoneFlag) else $error("short write");
  long_wr_a: assert property ($rose(accessControlReg[1]) &&
    addrLowReg[1:0] == 2'h3 && !accessControlReg[4]
    |=> skipInstr && cpuHalt && flashProgEn) else $error("long write");
  halt_len_a: assert property ($fell(cpuHalt) |->
    haltCnt_r >= LO && haltCnt_r <= HI) else $error("halt length");
  erase_go_a: assert property ($rose(accessControlReg[1]) &&
    accessControlReg[4] |-> cpuHalt ##[1:3] flashEraseEn)
    else $error("erase start");
  wr_permit_a: assert property ($rose(accessControlReg[1]) |->
    $past(accessControlReg[2])) else $error("trigger without permit");
  wr_protect_a: assert property (flashProgEn |->
    writeProtectConfig == 2'h3 ||
    (writeProtectConfig == 2'h1 && !flashAddr[ADDR_W-1]) ||
    (writeProtectConfig == 2'h2 && flashAddr[ADDR_W-1:ADDR_W-2] == 2'h0))
    else $error("protected write");
  done_hold_a: assert property (writeDoneFlag && !writeDoneClr
    |=> writeDoneFlag) else $error("flag lost");
endmodule
bind pfsp_ctrl pfsp_ctrl_props #(.ADDR_W(ADDR_W), .ERASE_CYC(ERASE_CYC),
  .WRITE_CYC(WRITE_CYC)) u_props (.mclk(mclk), .rst_n(rst_n),
  .writeDoneClr(writeDoneClr), .writeProtectConfig(writeProtectConfig),
  .flashAddr(flashAddr), .flashRdEn(flashRdEn),
  .flashEraseEn(flashEraseEn), .flashProgEn(flashProgEn),
  .addrLowReg(addrLowReg), .accessControlReg(accessControlReg),
  .skipInstr(skipInstr), .cpuHalt(cpuHalt), .writeDoneFlag(writeDoneFlag));

/* File: tb/pfsp_flash_model.sv */
// behavioural flash array facing the sequencer
`timescale 1ns/1ps
module pfsp_flash_model (
  input wire mclk,
  input wire [12:0] flashAddr,
  input wire flashRdEn,
  input wire flashEraseEn,
  input wire flashProgEn,
  input wire [55:0] flashProgData,
  output wire [13:0] flashRdData,
  output reg [12:0] eraseAddr,
  output reg [55:0] progSeen
);
  reg [13:0] junk_r = 14'h2aaa;
  // array answers while the strobe stands, junk toggles otherwise
  assign flashRdData = flashRdEn ? ({1'b1, flashAddr} ^ 14'h1555) : junk_r;
  always @(posedge mclk)
  begin
    junk_r <= ~junk_r;
    if (flashEraseEn)
      eraseAddr <= flashAddr;
    if (flashProgEn)
      progSeen <= flashProgData;
  end
endmodule

/* File: tb/test_program_flash_self_programming.sv */
// self-checking bench for the flash self-programming sequencer
`timescale 1ns/1ps
module test_program_flash_self_programming;
  reg mclk = 0;
  reg rst_n = 0;
  reg [6:0] we = 0;
  reg [7:0] wrData = 0;
  reg [1:0] wpCfg = 2'h3;
  reg doneClr = 0;
  reg abrt = 0;
  wire [13:0] rdData;
  wire [12:0] fAddr, eraseAddr;
  wire rdEn, eraseEn, progEn, skip, halt, done;
  wire [55:0] progData, progSeen;
  wire [7:0] aLo, aHi, dLo, acr;
  wire [5:0] dHi;
  integer err_count = 0;
  integer num_checks = 0;
  integer i;
  reg [31:0] r;
  reg [12:0] a;
  reg [1:0] w;
  reg [55:0] blk;
  always #2 mclk = ~mclk;
  pfsp_ctrl #(.ERASE_CYC(8), .WRITE_CYC(8)) dut (.mclk(mclk),
    .rst_n(rst_n), .clkEn(1'b1), .wrData(wrData), .addrLowWe(we[0]),
    .addrHighWe(we[1]), .dataLowWe(we[2]), .dataHighWe(we[3]),
    .ctrlWe(we[4]), .unlockWe(we[5]), .regAccess(we[6]),
    .writeProtectConfig(wpCfg), .abortReset(abrt), .writeDoneClr(doneClr),
    .flashRdData(rdData), .flashAddr(fAddr), .flashRdEn(rdEn),
    .flashEraseEn(eraseEn), .flashProgEn(progEn), .flashProgData(progData),
    .addrLowReg(aLo), .addrHighReg(aHi), .dataLowReg(dLo), .dataHighReg(dHi),
    .accessControlReg(acr), .skipInstr(skip), .cpuHalt(halt),
    .writeDoneFlag(done));
  pfsp_flash_model model (.mclk(mclk), .flashAddr(fAddr), .flashRdEn(rdEn),
    .flashEraseEn(eraseEn), .flashProgEn(progEn), .flashProgData(progData),
    .flashRdData(rdData), .eraseAddr(eraseAddr), .progSeen(progSeen));
  function [13:0] fexp(input [12:0] x);
    fexp = {1'b1, x} ^ 14'h1555;
  endfunction
  task end_sim;
    begin
      $display("checks %0d mismatches %0d", num_checks, err_count);
      if (err_count == 0 && num_checks > 0)
        $display("All checks passed");
      else
        $display("Checks failed");
      $finish;
    end
  endtask
  task chk(input [68:0] seen, input [68:0] exp);
    begin
      num_checks = num_checks + 1;
      if (seen !== exp)
      begin
        err_count = err_count + 1;
        $display("unexpected at %0t: got %h want %h", $time, seen, exp);
      end
    end
  endtask
  // a quiet cycle, then one strobe cycle
  task wr(input integer s, input [7:0] v);
    begin
      @(posedge mclk);
      #1 we = 7'h1 << s;
      wrData = v;
      @(posedge mclk);
      #1 we = 7'h0;
    end
  endtask
  task trig(input [7:0] c, input [7:0] k);
    begin
      wr(5, 8'h55);
      wr(5, k);
      wr(4, c);
    end
  endtask
  // bounded wait: k=1 for the read skip, k=0 for idle
  task wt(input integer k);
    integer n;
    begin
      n = 0;
      while (n < 60 && (k ? skip !== 1'b1 : (halt | acr[1]) !== 1'b0))
      begin
        @(posedge mclk);
        #1 n = n + 1;
      end
      if (n == 60)
      begin
        err_count = err_count + 1;
        end_sim;
      end
    end
  endtask
  initial
  begin
    r = $urandom(32'h2243);
    repeat (8) @(posedge mclk);
    #1 rst_n = 1;
    chk({acr, halt, done, skip}, 0);
    wr(4, 8'h80);
    for (i = 0; i < 3; i = i + 1)
    begin
      r = $urandom;
      a = (i == 0) ? 13'h0 : (i == 1) ? 13'h1fff : r[12:0];
      wr(1, {3'h0, a[12:8]});
      wr(0, a[7:0]);
      wr(4, 8'h81);
      wt(1);
      chk({dHi, dLo}, fexp(a));
      repeat (3) @(posedge mclk);
      chk({acr[0], dHi, dLo}, {1'b0, fexp(a)});
    end
    wr(0, 8'h03);
    trig(8'h82, 8'haa);
    chk(acr[1], 0);
    wr(4, 8'h84);
    trig(8'h86, 8'h55);
    chk(acr[1], 0);
    wr(5, 8'h55);
    wr(6, 8'h00);
    wr(5, 8'haa);
    wr(4, 8'h86);
    chk(acr[1], 0);
    wpCfg = 2'h1;
    wr(1, 8'h10);
    trig(8'h86, 8'haa);
    chk({acr[1], halt}, 0);
    wpCfg = 2'h2;
    r = $urandom;
    a = {2'h0, r[10:2], 2'h0};
    wr(1, {3'h0, a[12:8]});
    wr(0, a[7:0]);
    wr(4, 8'h94);
    trig(8'h96, 8'haa);
    wt(0);
    chk(eraseAddr, {a[12:5], 5'h0});
    wr(4, 8'h84);
    blk = {4{14'h3fff}};
    // second block only fills the last entry, so the rest show reset data
    for (i = 0; i < 5; i = i + 1)
    begin
      r = $urandom;
      w = (i < 4) ? i[1:0] : 2'h3;
      blk[w * 14 +: 14] = r[13:0];
      wr(0, {a[7:2], w});
      wr(2, r[7:0]);
      wr(3, {2'h0, r[13:8]});
      trig(8'h86, 8'haa);
      wt(0);
      if (i == 4)
        chk(progSeen, blk);
      else if (i == 3)
        chk(progSeen, blk);
      else
        chk({acr[1], done}, 2'h1);
      if (i == 3)
        blk = {4{14'h3fff}};
    end
    chk(done, 1);
    @(posedge mclk);
    #1 doneClr = 1;
    @(posedge mclk);
    #1 doneClr = 0;
    chk(done, 0);
    wpCfg = 2'h3;
    r = $urandom;
    wr(1, {3'h0, r[12:8]});
    wr(0, r[7:0]);
    wr(4, 8'h94);
    trig(8'h96, 8'haa);
    chk(halt, 1);
    @(posedge mclk);
    #1 abrt = 1;
    @(posedge mclk);
    #1 abrt = 0;
    chk(acr[3], 1);
    chk({aHi[4:0], aLo}, r[12:0]);
    wt(0);
    chk(eraseAddr[12:5], r[12:5]);
    end_sim;
  end
endmodule
